// file: include/ces_pkg.sv
// package for the configuration error status register bank
// assumes a single 125 MHz clock domain and a synchronous active-high reset
package ces_pkg;
	// ************************************************************
	// host port addresses
	// ************************************************************
	localparam logic [6:0] ERR_BYTE_ADDR_LO = 7'h08; // bytes 08h..0bh
	localparam logic [6:0] ERR_BYTE_ADDR_HI = 7'h0b;
	localparam logic [6:0] ERR_WORD_ADDR_LO = 7'h04; // words 04h..05h
	localparam logic [6:0] ERR_WORD_ADDR_HI = 7'h05;

	// ************************************************************
	// error_flags field positions
	// ************************************************************
	localparam int CARD_RESET_TIMEOUT_BIT = 0;
	localparam int CARD_READY_TIMEOUT_BIT = 1;
	localparam int CARD_READ_FAIL_BIT = 2;
	localparam int CARD_WRITE_FAIL_BIT = 3;
	localparam int SECTOR_VALID_TIMEOUT_BIT = 4;
	localparam int BAD_START_ADDRESS_BIT = 5;
	localparam int CHAIN_PROGRAM_FAIL_BIT = 6;
	localparam int BITSTREAM_READ_FAIL_BIT = 7;
	localparam int BAD_INSTRUCTION_BIT = 8;
	localparam int INIT_PIN_TIMEOUT_BIT = 9;
	localparam int CARD_BAD_BLOCK_BIT = 11;
	localparam int CARD_UNCORRECTABLE_BIT = 12;
	localparam int CARD_ID_MISSING_BIT = 13;
	localparam int CARD_ABORT_BIT = 14;
	localparam int CARD_GENERAL_ERROR_BIT = 15;

	// bit positions inside the card's own ata error register
	localparam int ATA_BBK_BIT = 7;
	localparam int ATA_UNC_BIT = 6;
	localparam int ATA_IDNF_BIT = 4;
	localparam int ATA_ABRT_BIT = 2;
	localparam int ATA_AMNF_BIT = 0;

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [31:0] ERROR_FLAGS_RESET = 32'h0000_0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam int CLK_MHZ = 125;
	localparam int INIT_TIMEOUT_MS = 500;
	localparam int INIT_TIMEOUT_CYCLES = INIT_TIMEOUT_MS * 1000 * CLK_MHZ;

	// ************************************************************
	// carriers
	// ************************************************************
	// one-cycle failure reports from the card and chain sequencers
	typedef struct packed {
		logic card_reset_timeout;
		logic card_ready_timeout;
		logic card_read_fail; // sector_read_command or card_identify_command
		logic card_write_fail; // sector_write_command
		logic sector_valid_timeout;
		logic chain_program_fail;
		logic bitstream_read_fail;
		logic bad_instruction;
	} ces_events_t;

	// start address check request
	typedef struct packed {
		logic check; // one-cycle pulse
		logic address_source_override; // 1: register field, 0: pins
		logic [15:0] start_address_select;
		logic [1:0] address_pins;
		logic [15:0] valid_count; // addresses below this are valid
	} ces_addr_check_t;

	typedef enum logic [1:0] {
		CES_INIT_IDLE = 2'b00,
		CES_INIT_WAIT = 2'b01,
		CES_INIT_DONE = 2'b11
	} ces_init_state_t;
endpackage

// file: src/ces_error_flags.sv
// error status register of the configuration controller, read over the host port
// assumes sequencers outside report failures as one-cycle pulses on CLK_I
`timescale 1ns/1ns

// Function
// - error register at bytes 08h-0bh in byte mode, words 04h-05h in word mode
// - bit 0 set when card reset does not finish before timeout
// - bit 1 set when card does not become ready before timeout
// - bit 2 set when sector read or identify command fails
// - bit 3 set when sector write command fails
// - bit 4 set when a sector does not become valid before timeout
// - bit 5 set when selected start address maps to no valid location
// - checked address comes from register field or pins, per override bit
// - bit 6 set when programming the target chain fails
// - bit 7 set when reading configuration data from the card fails
// - bit 8 set on an invalid instruction in configuration data
// - bit 9 set if init pin not high within 500 ms of start
// - bit 11 mirrors the card's bad-block error bit
// - bit 12 mirrors the card's uncorrectable-data error bit
// - bit 13 mirrors the card's id-not-found error bit
// - bit 14 mirrors the card's command-abort error bit
// - bit 15 mirrors the card's general-error bit
module ces_error_flags #(
	parameter int INIT_TIMEOUT = ces_pkg::INIT_TIMEOUT_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [6:0] ADDR_I,
	input wire logic RD_I,
	input wire logic WORD_MODE_I,
	input wire logic CLEAR_I,
	input wire ces_pkg::ces_events_t EVENTS_I,
	input wire ces_pkg::ces_addr_check_t ADDR_CHECK_I,
	input wire logic CFG_START_I,
	input wire logic TARGET_INIT_PIN_I,
	input wire logic [7:0] CARD_ATA_ERROR_I,
	output logic [15:0] DATA_O,
	output logic RD_HIT_O,
	output logic [31:0] ERROR_FLAGS_O
);
	import ces_pkg::*;

	// ************************************************************
	// sticky failure flags
	// ************************************************************
	logic [INIT_PIN_TIMEOUT_BIT:0] next_sticky_set;
	logic [INIT_PIN_TIMEOUT_BIT:0] sticky_flags;
	logic [CARD_GENERAL_ERROR_BIT:CARD_BAD_BLOCK_BIT] mirror_flags;
	logic [15:0] checked_address;
	logic init_timeout_hit;
	logic [25:0] init_count;
	ces_init_state_t init_state;

	// selected start address: register field or the two pins
	always_comb begin
		if (ADDR_CHECK_I.address_source_override) begin
			checked_address = ADDR_CHECK_I.start_address_select;
		end else begin
			checked_address = {14'h0000, ADDR_CHECK_I.address_pins};
		end
	end

	// gather this cycle's failure events into their bit slots
	always_comb begin
		next_sticky_set = 10'h000;
		next_sticky_set[CARD_RESET_TIMEOUT_BIT] = EVENTS_I.card_reset_timeout;
		next_sticky_set[CARD_READY_TIMEOUT_BIT] = EVENTS_I.card_ready_timeout;
		next_sticky_set[CARD_READ_FAIL_BIT] = EVENTS_I.card_read_fail;
		next_sticky_set[CARD_WRITE_FAIL_BIT] = EVENTS_I.card_write_fail;
		next_sticky_set[SECTOR_VALID_TIMEOUT_BIT] = EVENTS_I.sector_valid_timeout;
		next_sticky_set[BAD_START_ADDRESS_BIT] = ADDR_CHECK_I.check
			&& (checked_address >= ADDR_CHECK_I.valid_count);
		next_sticky_set[CHAIN_PROGRAM_FAIL_BIT] = EVENTS_I.chain_program_fail;
		next_sticky_set[BITSTREAM_READ_FAIL_BIT] = EVENTS_I.bitstream_read_fail;
		next_sticky_set[BAD_INSTRUCTION_BIT] = EVENTS_I.bad_instruction;
		next_sticky_set[INIT_PIN_TIMEOUT_BIT] = init_timeout_hit;
	end

	// flags hold until cleared; a set in the clearing cycle wins so no event is lost
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			sticky_flags <= ERROR_FLAGS_RESET[INIT_PIN_TIMEOUT_BIT:0];
		end else if (CLEAR_I) begin
			sticky_flags <= next_sticky_set;
		end else begin
			sticky_flags <= sticky_flags | next_sticky_set;
		end
	end

	// ************************************************************
	// card error mirrors and reserved bits
	// ************************************************************
	// mirrors follow the card register, one cycle behind, and are never sticky
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			mirror_flags <= ERROR_FLAGS_RESET[CARD_GENERAL_ERROR_BIT:CARD_BAD_BLOCK_BIT];
		end else begin
			mirror_flags[CARD_BAD_BLOCK_BIT] <= CARD_ATA_ERROR_I[ATA_BBK_BIT];
			mirror_flags[CARD_UNCORRECTABLE_BIT] <= CARD_ATA_ERROR_I[ATA_UNC_BIT];
			mirror_flags[CARD_ID_MISSING_BIT] <= CARD_ATA_ERROR_I[ATA_IDNF_BIT];
			mirror_flags[CARD_ABORT_BIT] <= CARD_ATA_ERROR_I[ATA_ABRT_BIT];
			mirror_flags[CARD_GENERAL_ERROR_BIT] <= CARD_ATA_ERROR_I[ATA_AMNF_BIT];
		end
	end

	// reserved bits are tied low so nothing can raise them; each live bit still comes from a flop
	assign ERROR_FLAGS_O = {16'h0000, mirror_flags, 1'b0, sticky_flags};

	// ************************************************************
	// init pin watchdog
	// ************************************************************
	// counts from configuration start; a new start restarts the watch
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			init_state <= CES_INIT_IDLE;
			init_count <= 26'h000_0000;
		end else if (CFG_START_I) begin
			init_state <= CES_INIT_WAIT;
			init_count <= 26'h000_0000;
		end else begin
			unique case (init_state)
				CES_INIT_IDLE: begin
					init_count <= 26'h000_0000;
				end
				CES_INIT_WAIT: begin
					if (TARGET_INIT_PIN_I || init_timeout_hit) begin
						init_state <= CES_INIT_DONE; // one report per start
					end
					init_count <= init_count + 26'h000_0001;
				end
				CES_INIT_DONE: begin
					init_count <= init_count;
				end
				default: begin
					init_state <= CES_INIT_IDLE;
				end
			endcase
		end
	end

	// pin still low when the full window has elapsed
	assign init_timeout_hit = (init_state == CES_INIT_WAIT) && !TARGET_INIT_PIN_I
		&& (init_count == 26'(INIT_TIMEOUT - 1));

	// ************************************************************
	// host port read
	// ************************************************************
	logic byte_hit;
	logic word_hit;
	logic [15:0] next_data;

	// writes are not decoded here at all, so the register is read-only
	always_comb begin
		byte_hit = !WORD_MODE_I && (ADDR_I >= ERR_BYTE_ADDR_LO) && (ADDR_I <= ERR_BYTE_ADDR_HI);
		word_hit = WORD_MODE_I && (ADDR_I >= ERR_WORD_ADDR_LO) && (ADDR_I <= ERR_WORD_ADDR_HI);
		next_data = 16'h0000;
		if (byte_hit) begin
			unique case (ADDR_I[1:0])
				2'h0: next_data = {8'h00, ERROR_FLAGS_O[7:0]};
				2'h1: next_data = {8'h00, ERROR_FLAGS_O[15:8]};
				2'h2: next_data = {8'h00, ERROR_FLAGS_O[23:16]};
				2'h3: next_data = {8'h00, ERROR_FLAGS_O[31:24]};
			endcase
		end else if (word_hit) begin
			next_data = ADDR_I[0] ? ERROR_FLAGS_O[31:16] : ERROR_FLAGS_O[15:0];
		end
	end

	// read data stands until the next read strobe
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			DATA_O <= DATA_RESET;
			RD_HIT_O <= 1'b0;
		end else begin
			RD_HIT_O <= RD_I && (byte_hit || word_hit);
			if (RD_I) begin
				DATA_O <= next_data;
			end
		end
	end

	// ************************************************************
	// check helpers
	// ************************************************************
	// age since the last start, kept apart from the watchdog so the checks do not lean on its counter;
	// it wraps after 2^26 cycles, harmless since only the first window after a start is compared
	logic [25:0] start_age;

	// restarts with every start pulse, as the watch window does
	always_ff @(posedge CLK_I) begin
		if (RST_I || CFG_START_I) begin
			start_age <= 26'h000_0000;
		end else begin
			start_age <= start_age + 26'h000_0001;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	// read port: lane selection, misses, and data that stands between strobes
	a_byte_read_low: assert property (RD_I && !WORD_MODE_I && ADDR_I == 7'h08
		|=> RD_HIT_O && DATA_O == {8'h00, $past(ERROR_FLAGS_O[7:0])})
		else $error("byte read of 08h returned wrong lane");
	a_byte_read_lane: assert property (RD_I && !WORD_MODE_I && ADDR_I == 7'h09
		|=> DATA_O == {8'h00, $past(ERROR_FLAGS_O[15:8])})
		else $error("byte read of 09h returned wrong lane");
	a_byte_read_top: assert property (RD_I && !WORD_MODE_I && ADDR_I == 7'h0b
		|=> RD_HIT_O && DATA_O == 16'h0000)
		else $error("byte read of 0bh not zero");
	a_word_read_low: assert property (RD_I && WORD_MODE_I && ADDR_I == 7'h04
		|=> RD_HIT_O && DATA_O == $past(ERROR_FLAGS_O[15:0]))
		else $error("word read of 04h returned wrong half");
	a_word_read_high: assert property (RD_I && WORD_MODE_I && ADDR_I == 7'h05
		|=> RD_HIT_O && DATA_O == $past(ERROR_FLAGS_O[31:16]))
		else $error("word read of 05h returned wrong half");
	a_read_miss_zero: assert property (RD_I && (WORD_MODE_I
		? (ADDR_I < ERR_WORD_ADDR_LO || ADDR_I > ERR_WORD_ADDR_HI)
		: (ADDR_I < ERR_BYTE_ADDR_LO || ADDR_I > ERR_BYTE_ADDR_HI)) |=> !RD_HIT_O && DATA_O == 16'h0000)
		else $error("read outside the register answered");
	a_hit_needs_read: assert property (RD_HIT_O |-> $past(RD_I))
		else $error("read hit without a read strobe");
	a_data_holds: assert property (!RD_I |=> $stable(DATA_O))
		else $error("read data changed without a read strobe");

	// sticky flags: each event sets its bit, even in a clearing cycle, and bit 0 rises on nothing else
	a_reset_flag_set: assert property (EVENTS_I.card_reset_timeout |=> ERROR_FLAGS_O[0])
		else $error("card reset timeout not flagged");
	a_reset_flag_quiet: assert property (!ERROR_FLAGS_O[0] && !EVENTS_I.card_reset_timeout
		|=> !ERROR_FLAGS_O[0])
		else $error("card reset flag set with no timeout");
	a_ready_flag_set: assert property (EVENTS_I.card_ready_timeout |=> ERROR_FLAGS_O[1])
		else $error("card ready timeout not flagged");
	a_read_flag_set: assert property (EVENTS_I.card_read_fail |=> ERROR_FLAGS_O[2])
		else $error("card read failure not flagged");
	a_write_flag_set: assert property (EVENTS_I.card_write_fail |=> ERROR_FLAGS_O[3])
		else $error("card write failure not flagged");
	a_sector_flag_set: assert property (EVENTS_I.sector_valid_timeout |=> ERROR_FLAGS_O[4])
		else $error("sector timeout not flagged");
	a_chain_flags_set: assert property (EVENTS_I.chain_program_fail |=> ERROR_FLAGS_O[6])
		else $error("chain failure not flagged");
	a_bitstream_flag_set: assert property (EVENTS_I.bitstream_read_fail |=> ERROR_FLAGS_O[7])
		else $error("bitstream read failure not flagged");
	a_instr_flag_set: assert property (EVENTS_I.bad_instruction |=> ERROR_FLAGS_O[8])
		else $error("bad instruction not flagged");
	a_instr_flag_sticky: assert property (ERROR_FLAGS_O[8] && !CLEAR_I |=> ERROR_FLAGS_O[8])
		else $error("bad instruction flag dropped without clear");
	a_flags_sticky: assert property (!CLEAR_I
		|=> (ERROR_FLAGS_O[9:0] & $past(ERROR_FLAGS_O[9:0])) == $past(ERROR_FLAGS_O[9:0]))
		else $error("sticky flag dropped without clear");
	a_clear_drops: assert property (CLEAR_I && EVENTS_I == '0 && !ADDR_CHECK_I.check
		&& !init_timeout_hit |=> ERROR_FLAGS_O[9:0] == 10'h000)
		else $error("clear left a flag standing");

	// start address check from either source
	a_bad_address_field: assert property (ADDR_CHECK_I.check && ADDR_CHECK_I.address_source_override
		&& ADDR_CHECK_I.start_address_select >= ADDR_CHECK_I.valid_count |=> ERROR_FLAGS_O[5])
		else $error("bad field address not flagged");
	a_bad_address_pins: assert property (ADDR_CHECK_I.check && !ADDR_CHECK_I.address_source_override
		&& {14'h0000, ADDR_CHECK_I.address_pins} >= ADDR_CHECK_I.valid_count |=> ERROR_FLAGS_O[5])
		else $error("bad pin address not flagged");
	a_good_address_clean: assert property (!ERROR_FLAGS_O[5] && ADDR_CHECK_I.check && !CLEAR_I
		&& checked_address < ADDR_CHECK_I.valid_count |=> !ERROR_FLAGS_O[5])
		else $error("valid start address flagged");

	// init watchdog: one report per start, only at the full window, and a new start rearms it
	a_init_timeout_flag: assert property (init_timeout_hit && !CFG_START_I
		|=> ERROR_FLAGS_O[9] && init_state == CES_INIT_DONE)
		else $error("init timeout not reported");
	a_init_flag_age: assert property ($rose(ERROR_FLAGS_O[9])
		|-> $past(start_age) == 26'(INIT_TIMEOUT - 1))
		else $error("init timeout flagged at the wrong time");
	a_init_pin_early: assert property (init_state == CES_INIT_WAIT && TARGET_INIT_PIN_I && !CFG_START_I
		|=> init_state == CES_INIT_DONE && !$rose(ERROR_FLAGS_O[9]))
		else $error("early init pin not accepted");
	a_init_restart: assert property (CFG_START_I
		|=> init_state == CES_INIT_WAIT && init_count == 26'h000_0000)
		else $error("start did not rearm the init watchdog");
	a_init_one_report: assert property (init_state == CES_INIT_DONE && !CFG_START_I
		|=> init_state == CES_INIT_DONE)
		else $error("init watchdog left done without a start");

	// card mirrors and reserved bits
	a_mirror_follow: assert property (##1 ERROR_FLAGS_O[15:11] == {$past(CARD_ATA_ERROR_I[0]),
		$past(CARD_ATA_ERROR_I[2]), $past(CARD_ATA_ERROR_I[4]), $past(CARD_ATA_ERROR_I[6]),
		$past(CARD_ATA_ERROR_I[7])})
		else $error("card error mirrors out of step");
	a_reserved_zero: assert property (ERROR_FLAGS_O[10] == 1'b0 && ERROR_FLAGS_O[31:16] == 16'h0000)
		else $error("reserved bits not zero");

	// covers for the main scenarios: a hit read in each mode, set against clear, timeout, bad address
	c_byte_read: cover property (RD_I && !WORD_MODE_I && ADDR_I == ERR_BYTE_ADDR_LO ##1 RD_HIT_O);
	c_word_read: cover property (RD_I && WORD_MODE_I && ADDR_I == ERR_WORD_ADDR_HI ##1 RD_HIT_O);
	c_set_on_clear: cover property (CLEAR_I && EVENTS_I.card_read_fail ##1 ERROR_FLAGS_O[2]);
	c_init_timeout: cover property (init_timeout_hit);
	c_bad_address: cover property (next_sticky_set[BAD_START_ADDRESS_BIT]);
endmodule

// file: sim/ces_far_side.sv
// behavioural model of the flash card error register and the target chain init pin
// assumes the bench picks the card's error value and how long the chain holds init low
`timescale 1ns/1ns
module ces_far_side (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cfg_start_i,
	input wire logic signed [31:0] init_delay_i,
	input wire logic [7:0] ata_value_i,
	output logic target_init_pin_o,
	output logic [7:0] card_ata_error_o
);
	int count;

	// init pin is held low from start; a negative delay models a chain that never finishes
	always_ff @(posedge clk_i) begin
		if (rst_i || cfg_start_i) begin
			count <= 0;
			target_init_pin_o <= 1'b0;
		end else if (init_delay_i >= 0 && count >= init_delay_i) begin
			target_init_pin_o <= 1'b1;
		end else begin
			count <= count + 1;
		end
	end

	// card error register changes only on the clock, as a card register read would
	always_ff @(posedge clk_i) begin
		card_ata_error_o <= rst_i ? 8'h00 : ata_value_i;
	end
endmodule

// file: sim/tb.sv
// self-checking bench for the error status register bank
// assumes one 125 MHz clock, inputs driven on the falling edge, a short init timeout
`timescale 1ns/1ns
module tb;
	import ces_pkg::*;
	localparam int TMO = 20; // shortened init watchdog so the run stays small
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic [6:0] ADDR_I = 7'h00;
	logic RD_I = 1'b0;
	logic WORD_MODE_I = 1'b0;
	logic CLEAR_I = 1'b0;
	ces_events_t EVENTS_I = '0;
	ces_addr_check_t ADDR_CHECK_I = '0;
	logic CFG_START_I = 1'b0;
	logic TARGET_INIT_PIN_I;
	logic [7:0] CARD_ATA_ERROR_I;
	logic [15:0] DATA_O;
	logic RD_HIT_O;
	logic [31:0] ERROR_FLAGS_O;
	logic [7:0] ata_value = 8'h00;
	int init_delay = -1;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] exp_flags = '0;

	// ************************************************************
	// design and far side
	// ************************************************************
	ces_error_flags #(.INIT_TIMEOUT(TMO)) i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
		.WORD_MODE_I(WORD_MODE_I), .CLEAR_I(CLEAR_I), .EVENTS_I(EVENTS_I), .ADDR_CHECK_I(ADDR_CHECK_I),
		.CFG_START_I(CFG_START_I), .TARGET_INIT_PIN_I(TARGET_INIT_PIN_I), .CARD_ATA_ERROR_I(CARD_ATA_ERROR_I),
		.DATA_O(DATA_O), .RD_HIT_O(RD_HIT_O), .ERROR_FLAGS_O(ERROR_FLAGS_O));
	ces_far_side i_far (.clk_i(CLK_I), .rst_i(RST_I), .cfg_start_i(CFG_START_I), .init_delay_i(init_delay),
		.ata_value_i(ata_value), .target_init_pin_o(TARGET_INIT_PIN_I), .card_ata_error_o(CARD_ATA_ERROR_I));

	// ************************************************************
	// clock, watchdog and tasks
	// ************************************************************
	initial begin
		forever #4 CLK_I = ~CLK_I;
	end

	// a hang is cut off well beyond the under two hundred cycles the sequence needs
	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// one read strobe; answer is looked at in the cycle after the taking edge
	task automatic read_reg(input logic [6:0] addr, input logic word, input logic [15:0] want, input logic hit);
		@(negedge CLK_I);
		ADDR_I = addr;
		WORD_MODE_I = word;
		RD_I = 1'b1;
		@(negedge CLK_I);
		RD_I = 1'b0;
		check({31'h0, RD_HIT_O}, {31'h0, hit});
		check({16'h0, DATA_O}, {16'h0, want});
	endtask

	// every byte and word lane, then misses just outside and in the wrong mode
	task automatic read_all();
		check(ERROR_FLAGS_O, exp_flags);
		for (int b = 0; b < 4; b++) read_reg(7'h08 + 7'(b), 1'b0, 16'(exp_flags[8*b +: 8]), 1'b1);
		for (int w = 0; w < 2; w++) read_reg(7'h04 + 7'(w), 1'b1, exp_flags[16*w +: 16], 1'b1);
		read_reg(7'h0c, 1'b0, 16'h0000, 1'b0);
		read_reg(7'h04, 1'b0, 16'h0000, 1'b0);
		read_reg(7'h06, 1'b1, 16'h0000, 1'b0);
	endtask

	task automatic fire(input int idx, input int pos);
		@(negedge CLK_I);
		EVENTS_I[idx] = 1'b1;
		@(negedge CLK_I);
		EVENTS_I = '0;
		exp_flags[pos] = 1'b1;
		check(ERROR_FLAGS_O, exp_flags);
	endtask

	task automatic clear_all();
		@(negedge CLK_I);
		CLEAR_I = 1'b1;
		@(negedge CLK_I);
		CLEAR_I = 1'b0;
		exp_flags[9:0] = '0;
	endtask

	task automatic addr_check(input logic ovr, input logic [15:0] field, input logic [1:0] pins,
		input logic [15:0] limit, input logic bad);
		@(negedge CLK_I);
		ADDR_CHECK_I = '{1'b1, ovr, field, pins, limit};
		@(negedge CLK_I);
		ADDR_CHECK_I.check = 1'b0;
		check({31'h0, ERROR_FLAGS_O[5]}, {31'h0, bad});
		clear_all();
	endtask

	// start configuration; the flag must be absent just before the timeout and equal flag after it (set only if the pin was still low)
	task automatic init_run(input int delay, input logic flag);
		init_delay = delay;
		@(negedge CLK_I);
		CFG_START_I = 1'b1;
		@(negedge CLK_I);
		CFG_START_I = 1'b0;
		repeat (TMO - 2) @(negedge CLK_I);
		check({31'h0, ERROR_FLAGS_O[9]}, 32'h0);
		repeat (3) @(negedge CLK_I);
		check({31'h0, ERROR_FLAGS_O[9]}, {31'h0, flag});
		clear_all();
	endtask

	task automatic mirror(input logic [7:0] ata, input logic [4:0] bits);
		ata_value = ata;
		repeat (3) @(negedge CLK_I);
		check({16'h0, ERROR_FLAGS_O[15:0]}, {16'h0, bits, 11'h000});
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (2) @(negedge CLK_I);
		RST_I = 1'b0;
		read_all();
		fire(7, 0);
		fire(6, 1);
		fire(5, 2);
		fire(4, 3);
		fire(3, 4);
		fire(2, 6);
		fire(1, 7);
		fire(0, 8);
		read_all();
		clear_all();
		check(ERROR_FLAGS_O, 32'h0);
		addr_check(1'b1, 16'h0010, 2'b00, 16'h0010, 1'b1);
		addr_check(1'b1, 16'h0002, 2'b11, 16'h0003, 1'b0);
		addr_check(1'b0, 16'h0002, 2'b11, 16'h0003, 1'b1);
		addr_check(1'b0, 16'hffff, 2'b10, 16'h0003, 1'b0);
		init_run(-1, 1'b1);
		init_run(TMO / 2, 1'b0);
		init_run(TMO + 5, 1'b1);
		mirror(8'h80, 5'h01);
		mirror(8'h40, 5'h02);
		mirror(8'h10, 5'h04);
		mirror(8'h04, 5'h08);
		mirror(8'h01, 5'h10);
		mirror(8'h2a, 5'h00);
		mirror(8'hff, 5'h1f);
		clear_all();
		exp_flags[15:11] = 5'h1f;
		read_all();
		close_out();
	end
endmodule
